// File: pbq_pkg.sv
package pbq_pkg;
   localparam int NPKT = 16;
   localparam int PNW = 4;
   localparam int NPAGE = 32;
   localparam int PGW = 6;
   localparam int MAXPG = 8;
   localparam int OFFW = 9;
   localparam int MAW = 13;
   localparam int QCW = 5;
   // register indices on the plain register port
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_CMD = 4'h1;
   localparam logic [3:0] REG_PNR = 4'h2;
   localparam logic [3:0] REG_ALLOC = 4'h3;
   localparam logic [3:0] REG_FIFO = 4'h4;
   localparam logic [3:0] REG_INT = 4'h5;
   localparam logic [3:0] REG_MASK = 4'h6;
   localparam logic [3:0] REG_PORT = 4'h7;
   // control bits
   localparam int CTRL_TXEN = 0;
   localparam int CTRL_RECEIVE_ENABLE_BIT = 1;
   localparam int CTRL_AUTO = 2;
   localparam int CTRL_BADSEL = 3;
   localparam int CTRL_FDX = 4;
   localparam logic [15:0] CTRL_RST = 16'h0004;
   localparam logic [15:0] CTRL_MASK = 16'h001F;
   // command field
   localparam int CMD_LSB = 13;
   localparam logic [2:0] CMD_ALLOC = 3'h1;
   localparam logic [2:0] CMD_ENQ = 3'h2;
   localparam logic [2:0] CMD_REL = 3'h3;
   localparam logic [2:0] CMD_RXREL = 3'h4;
   // interrupt bits
   localparam int NINT = 5;
   localparam int INT_RX = 0;
   localparam int INT_TX = 1;
   localparam int INT_DRAIN = 2;
   localparam int INT_ALLOC = 3;
   localparam int INT_RXBAD = 4;
   localparam logic [9:0] OFF_FIRST = 10'h002;

   typedef struct packed {
      logic [15:0] status;
      logic [10:0] bytes;
      logic crc_ok;
   } rx_end_t;

   typedef struct packed {
      logic we;
      logic [MAW-1:0] addr;
      logic [31:0] data;
   } mem_wr_t;

   // pages needed for a byte count, never less than one
   function automatic logic [3:0] pages_of(input logic [10:0] b);
      logic [11:0] s;
      s = {1'h0, b} + 12'h0FF;
      return (s[11:8] == 4'h0) ? 4'h1 : s[11:8];
   endfunction

   // logical word offset of a packet to physical buffer address
   function automatic logic [MAW-1:0] phys(input logic [PNW-1:0] pn, input logic [9:0] off);
      return {pn, off[OFFW-1:0]};
   endfunction
endpackage

// File: packet_buffer_queue_manager.sv
// Local design decisions: the address map and the strobed register port.
`timescale 1ns/10ps
module packet_buffer_queue_manager (
   input wire logic clk_i, // device clock
   input wire logic srst_i, // synchronous reset, high
   input wire logic [3:0] reg_addr_i, // register index
   input wire logic [15:0] reg_wdata_i, // write data
   input wire logic reg_wr_i, // write strobe
   input wire logic reg_rd_i, // read strobe
   output logic [15:0] reg_rdata_o, // read data, cycle after strobe
   output logic irq_o, // masked interrupt level
   input wire logic tx_defer_ok_i, // half-duplex deferral permits send
   output logic tx_start_o, // pulse: packet handed to MAC
   output logic [3:0] tx_pkt_o, // packet number being sent
   input wire logic tx_done_i, // pulse: transmission finished
   input wire logic tx_ok_i, // with done: success
   input wire logic rx_start_i, // pulse: address-matched frame begins
   input wire logic rx_word_valid_i, // receive word valid
   input wire logic [31:0] rx_word_i, // receive word
   input wire logic rx_end_i, // pulse: frame end
   input wire pbq_pkg::rx_end_t rx_end_info_i, // status, byte count, crc result
   output logic rx_drop_o, // pulse: frame dropped on overrun
   output pbq_pkg::mem_wr_t mem_wr_o // packet buffer write port
);

   typedef enum logic [3:0] {
      RX_IDLE = 4'b0001,
      RX_DATA = 4'b0010,
      RX_STAT = 4'b0100,
      RX_CNT = 4'b1000
   } rx_state_t;

   // host-visible state
   logic [15:0] ctrl_q, ctrl_d;
   logic [3:0] pnr_q, pnr_d;
   logic [pbq_pkg::NINT-1:0] int_q, int_d, mask_q, mask_d;
   logic [3:0] fail_q, fail_d;
   logic last_ok_q, last_ok_d;
   logic [15:0] rdata_q, rdata_d;
   // memory manager state
   logic [pbq_pkg::NPKT-1:0] free_q, free_d;
   logic [3:0] pg_q [pbq_pkg::NPKT];
   logic [3:0] pg_d [pbq_pkg::NPKT];
   logic [pbq_pkg::PGW-1:0] fpg_q, fpg_d;
   logic apend_q, apend_d;
   logic [3:0] aneed_q, aneed_d;
   logic [3:0] ares_q, ares_d;
   // queues and transmit path
   logic [3:0] tq_q [pbq_pkg::NPKT];
   logic [3:0] tq_d [pbq_pkg::NPKT];
   logic [3:0] rq_q [pbq_pkg::NPKT];
   logic [3:0] rq_d [pbq_pkg::NPKT];
   logic [3:0] tw_q, tw_d, tr_q, tr_d, rw_q, rw_d, rr_q, rr_d;
   logic [pbq_pkg::QCW-1:0] tc_q, tc_d, rc_q, rc_d;
   logic tbusy_q, tbusy_d, tstart_q, tstart_d;
   logic [3:0] tpkt_q, tpkt_d;
   // receive path
   rx_state_t st_q, st_d;
   logic [3:0] rpn_q, rpn_d;
   logic [9:0] off_q, off_d;
   pbq_pkg::rx_end_t end_q, end_d;
   pbq_pkg::mem_wr_t mem_q, mem_d;
   logic drop_q, drop_d;

   logic [2:0] cmd;
   logic cmd_wr, alloc_cmd, enq_cmd, rel_cmd, rxrel_cmd;
   logic tx_go, fin_ok, fin_bad, rx_pop;
   logic any_free, rx_pn_ok, rx_pg_ok, host_ok;
   logic [3:0] ff;
   logic [9:0] cap;
   logic room, want_pn, want_pg, drop_rel, bad_rel, rx_push;
   logic [pbq_pkg::NINT-1:0] stat;

   // lowest free packet number
   function automatic logic [3:0] first_free(input logic [pbq_pkg::NPKT-1:0] m);
      logic [3:0] r;
      r = 4'h0;
      for (int i = pbq_pkg::NPKT - 1; i >= 0; i--)
      begin
         if (m[i])
         begin
            r = 4'(i);
         end
      end
      return r;
   endfunction

   // ************************************************************
   // command decode and event terms
   // ************************************************************

   // commands act in the cycle of the write strobe
   assign cmd = reg_wdata_i[pbq_pkg::CMD_LSB +: 3];
   assign cmd_wr = reg_wr_i && (reg_addr_i == pbq_pkg::REG_CMD);
   assign alloc_cmd = cmd_wr && (cmd == pbq_pkg::CMD_ALLOC);
   assign enq_cmd = cmd_wr && (cmd == pbq_pkg::CMD_ENQ);
   assign rel_cmd = cmd_wr && (cmd == pbq_pkg::CMD_REL);
   assign rxrel_cmd = cmd_wr && (cmd == pbq_pkg::CMD_RXREL);
   // send only when enabled and, in half duplex, when deferral allows
   assign tx_go = !tbusy_q && (tc_q != 5'h00) && ctrl_q[pbq_pkg::CTRL_TXEN]
      && (ctrl_q[pbq_pkg::CTRL_FDX] || tx_defer_ok_i);
   assign fin_ok = tx_done_i && tbusy_q && tx_ok_i;
   assign fin_bad = tx_done_i && tbusy_q && !tx_ok_i;
   assign rx_pop = rxrel_cmd && (rc_q != 5'h00);

   // receive wants never depend on grants, which keeps the loop open
   assign cap = {pg_q[rpn_q], 6'h00};
   assign room = off_q < cap;
   assign want_pn = (st_q == RX_IDLE) && rx_start_i && ctrl_q[pbq_pkg::CTRL_RECEIVE_ENABLE_BIT];
   assign want_pg = (st_q == RX_DATA) && rx_word_valid_i && !room && (pg_q[rpn_q] != 4'(pbq_pkg::MAXPG));
   assign drop_rel = (st_q == RX_DATA) && rx_word_valid_i && !room && !rx_pg_ok;
   assign bad_rel = (st_q == RX_CNT) && !end_q.crc_ok;
   assign rx_push = (st_q == RX_CNT) && end_q.crc_ok;

   // grants: receive before host so a frame never waits on software
   assign any_free = |free_q;
   assign ff = first_free(free_q);
   assign rx_pn_ok = want_pn && any_free && (fpg_q != 6'h00);
   assign rx_pg_ok = want_pg && (fpg_q != 6'h00);
   assign host_ok = apend_q && !want_pn && !want_pg && any_free && (fpg_q >= {2'h0, aneed_q});

   // ************************************************************
   // memory manager
   // ************************************************************

   // frees are summed first, then at most one grant takes pages
   always_comb
   begin
      logic [pbq_pkg::NPKT-1:0] rel;
      logic [pbq_pkg::PGW:0] add;
      logic [pbq_pkg::PGW:0] take;
      rel = '0;
      add = 7'h00;
      take = 7'h00;
      free_d = free_q;
      pg_d = pg_q;
      apend_d = apend_q;
      aneed_d = aneed_q;
      ares_d = ares_q;
      if (fin_ok && ctrl_q[pbq_pkg::CTRL_AUTO])
      begin
         rel[tpkt_q] = 1'h1;
      end
      if (rel_cmd)
      begin
         rel[pnr_q] = 1'h1;
      end
      if (rx_pop)
      begin
         rel[rq_q[rr_q]] = 1'h1;
      end
      if (drop_rel || bad_rel)
      begin
         rel[rpn_q] = 1'h1;
      end
      for (int i = 0; i < pbq_pkg::NPKT; i++)
      begin
         if (rel[i])
         begin
            add = add + {3'h0, pg_q[i]};
            free_d[i] = 1'h1;
            pg_d[i] = 4'h0;
         end
      end
      if (rx_pn_ok)
      begin
         free_d[ff] = 1'h0;
         pg_d[ff] = 4'h1;
         take = 7'h01;
      end
      else if (rx_pg_ok)
      begin
         pg_d[rpn_q] = pg_q[rpn_q] + 4'h1;
         take = 7'h01;
      end
      else if (host_ok)
      begin
         free_d[ff] = 1'h0;
         pg_d[ff] = aneed_q;
         take = {3'h0, aneed_q};
         apend_d = 1'h0;
         ares_d = ff;
      end
      if (alloc_cmd)
      begin
         apend_d = 1'h1;
         aneed_d = pbq_pkg::pages_of(reg_wdata_i[10:0]);
      end
      fpg_d = 6'({1'h0, fpg_q} + add - take);
   end

   // memory manager registers
   always_ff @(posedge clk_i)
   begin
      if (srst_i)
      begin
         free_q <= '1;
         pg_q <= '{default: 4'h0};
         fpg_q <= 6'(pbq_pkg::NPAGE);
         apend_q <= 1'h0;
         aneed_q <= 4'h0;
         ares_q <= 4'h0;
      end
      else
      begin
         free_q <= free_d;
         pg_q <= pg_d;
         fpg_q <= fpg_d;
         apend_q <= apend_d;
         aneed_q <= aneed_d;
         ares_q <= ares_d;
      end
   end

   // ************************************************************
   // packet queues and transmit hand-off
   // ************************************************************

   // a push onto a full queue is ignored, so a double enqueue cannot wrap
   always_comb
   begin
      tq_d = tq_q;
      tw_d = tw_q;
      tr_d = tr_q;
      tc_d = tc_q;
      rq_d = rq_q;
      rw_d = rw_q;
      rr_d = rr_q;
      rc_d = rc_q;
      tbusy_d = tbusy_q;
      tpkt_d = tpkt_q;
      tstart_d = tx_go;
      if (enq_cmd && (tc_q != 5'(pbq_pkg::NPKT)))
      begin
         tq_d[tw_q] = pnr_q;
         tw_d = tw_q + 4'h1;
         tc_d = tc_d + 5'h01;
      end
      if (tx_go)
      begin
         tpkt_d = tq_q[tr_q];
         tr_d = tr_q + 4'h1;
         tc_d = tc_d - 5'h01;
         tbusy_d = 1'h1;
      end
      else if (tx_done_i)
      begin
         tbusy_d = 1'h0;
      end
      if (rx_push && (rc_q != 5'(pbq_pkg::NPKT)))
      begin
         rq_d[rw_q] = rpn_q;
         rw_d = rw_q + 4'h1;
         rc_d = rc_d + 5'h01;
      end
      if (rx_pop)
      begin
         rr_d = rr_q + 4'h1;
         rc_d = rc_d - 5'h01;
      end
   end

   // queue registers
   always_ff @(posedge clk_i)
   begin
      if (srst_i)
      begin
         tq_q <= '{default: 4'h0};
         rq_q <= '{default: 4'h0};
         tw_q <= 4'h0;
         tr_q <= 4'h0;
         tc_q <= 5'h00;
         rw_q <= 4'h0;
         rr_q <= 4'h0;
         rc_q <= 5'h00;
         tbusy_q <= 1'h0;
         tpkt_q <= 4'h0;
         tstart_q <= 1'h0;
      end
      else
      begin
         tq_q <= tq_d;
         rq_q <= rq_d;
         tw_q <= tw_d;
         tr_q <= tr_d;
         tc_q <= tc_d;
         rw_q <= rw_d;
         rr_q <= rr_d;
         rc_q <= rc_d;
         tbusy_q <= tbusy_d;
         tpkt_q <= tpkt_d;
         tstart_q <= tstart_d;
      end
   end

   // ************************************************************
   // receive engine
   // ************************************************************

   // data starts at word two; words zero and one are filled at frame end
   always_comb
   begin
      st_d = st_q;
      rpn_d = rpn_q;
      off_d = off_q;
      end_d = end_q;
      mem_d = '0;
      drop_d = 1'h0;
      case (st_q)
         RX_IDLE:
         begin
            if (want_pn)
            begin
               if (rx_pn_ok)
               begin
                  rpn_d = ff;
                  off_d = pbq_pkg::OFF_FIRST;
                  st_d = RX_DATA;
               end
               else
               begin
                  drop_d = 1'h1; // no memory at all: frame lost
               end
            end
         end
         RX_DATA:
         begin
            if (rx_word_valid_i)
            begin
               if (room || rx_pg_ok)
               begin
                  mem_d.we = 1'h1;
                  mem_d.addr = pbq_pkg::phys(rpn_q, off_q);
                  mem_d.data = rx_word_i;
                  off_d = off_q + 10'h001;
               end
               else
               begin
                  drop_d = 1'h1;
                  st_d = RX_IDLE;
               end
            end
            else if (rx_end_i)
            begin
               end_d = rx_end_info_i;
               st_d = RX_STAT;
            end
         end
         RX_STAT:
         begin
            mem_d.we = 1'h1;
            mem_d.addr = pbq_pkg::phys(rpn_q, 10'h000);
            mem_d.data = {16'h0000, end_q.status};
            st_d = RX_CNT;
         end
         RX_CNT:
         begin
            mem_d.we = 1'h1;
            mem_d.addr = pbq_pkg::phys(rpn_q, 10'h001);
            mem_d.data = {21'h000000, end_q.bytes};
            st_d = RX_IDLE;
         end
         default:
         begin
            st_d = RX_IDLE;
         end
      endcase
   end

   // receive registers
   always_ff @(posedge clk_i)
   begin
      if (srst_i)
      begin
         st_q <= RX_IDLE;
         rpn_q <= 4'h0;
         off_q <= 10'h000;
         end_q <= '0;
         mem_q <= '0;
         drop_q <= 1'h0;
      end
      else
      begin
         st_q <= st_d;
         rpn_q <= rpn_d;
         off_q <= off_d;
         end_q <= end_d;
         mem_q <= mem_d;
         drop_q <= drop_d;
      end
   end

   // ************************************************************
   // host registers and flags
   // ************************************************************

   // receive flag is a level of the queue, so it cannot be cleared early
   assign stat = {int_q[pbq_pkg::NINT-1:1], (rc_q != 5'h00) || int_q[pbq_pkg::INT_RXBAD]};

   // clears come first so a same-cycle event still sets its flag
   always_comb
   begin
      ctrl_d = ctrl_q;
      pnr_d = pnr_q;
      mask_d = mask_q;
      int_d = int_q;
      fail_d = fail_q;
      last_ok_d = last_ok_q;
      rdata_d = 16'h0000;
      if (reg_wr_i)
      begin
         case (reg_addr_i)
            pbq_pkg::REG_CTRL: ctrl_d = reg_wdata_i & pbq_pkg::CTRL_MASK;
            pbq_pkg::REG_PNR: pnr_d = reg_wdata_i[3:0];
            pbq_pkg::REG_MASK: mask_d = reg_wdata_i[pbq_pkg::NINT-1:0];
            pbq_pkg::REG_INT: int_d = int_q & ~reg_wdata_i[pbq_pkg::NINT-1:0];
            default: ctrl_d = ctrl_d;
         endcase
      end
      if (fin_bad)
      begin
         ctrl_d[pbq_pkg::CTRL_TXEN] = 1'h0;
         int_d[pbq_pkg::INT_TX] = 1'h1;
         fail_d = tpkt_q;
      end
      if (tx_done_i && tbusy_q)
      begin
         last_ok_d = tx_ok_i;
      end
      if (fin_ok && (tc_q == 5'h00))
      begin
         int_d[pbq_pkg::INT_DRAIN] = 1'h1;
      end
      if (host_ok)
      begin
         int_d[pbq_pkg::INT_ALLOC] = 1'h1;
      end
      if (bad_rel && ctrl_q[pbq_pkg::CTRL_BADSEL])
      begin
         int_d[pbq_pkg::INT_RXBAD] = 1'h1;
      end
      int_d[pbq_pkg::INT_RX] = 1'h0;
      if (reg_rd_i)
      begin
         case (reg_addr_i)
            pbq_pkg::REG_CTRL: rdata_d = ctrl_q;
            pbq_pkg::REG_CMD: rdata_d = {15'h0000, apend_q};
            pbq_pkg::REG_PNR: rdata_d = {12'h000, pnr_q};
            pbq_pkg::REG_ALLOC: rdata_d = {8'h00, apend_q, 3'h0, ares_q};
            pbq_pkg::REG_FIFO: rdata_d = {rc_q == 5'h00, 3'h0, rq_q[rr_q], tc_q == 5'h00, 3'h0, fail_q};
            pbq_pkg::REG_INT: rdata_d = {11'h000, stat};
            pbq_pkg::REG_MASK: rdata_d = {11'h000, mask_q};
            pbq_pkg::REG_PORT: rdata_d = {2'h0, fpg_q, 7'h00, last_ok_q};
            default: rdata_d = 16'h0000;
         endcase
      end
   end

   // host register file
   always_ff @(posedge clk_i)
   begin
      if (srst_i)
      begin
         ctrl_q <= pbq_pkg::CTRL_RST;
         pnr_q <= 4'h0;
         mask_q <= '0;
         int_q <= '0;
         fail_q <= 4'h0;
         last_ok_q <= 1'h0;
         rdata_q <= 16'h0000;
      end
      else
      begin
         ctrl_q <= ctrl_d;
         pnr_q <= pnr_d;
         mask_q <= mask_d;
         int_q <= int_d;
         fail_q <= fail_d;
         last_ok_q <= last_ok_d;
         rdata_q <= rdata_d;
      end
   end

   // outputs, all from flops except the masked interrupt
   assign reg_rdata_o = rdata_q;
   assign irq_o = |(stat & mask_q);
   assign tx_start_o = tstart_q;
   assign tx_pkt_o = tpkt_q;
   assign rx_drop_o = drop_q;
   assign mem_wr_o = mem_q;

endmodule

// File: pbq_assertions.sv
`timescale 1ns/10ps
module pbq_checker (
   input wire logic clk_i, // clock
   input wire logic srst_i, // reset
   input wire logic [3:0] reg_addr_i, // index
   input wire logic [15:0] reg_wdata_i, // wdata
   input wire logic reg_wr_i, // write
   input wire logic reg_rd_i, // read
   input wire logic [15:0] reg_rdata_o, // rdata
   input wire logic irq_o, // irq
   input wire logic tx_defer_ok_i, // defer ok
   input wire logic tx_start_o, // start
   input wire logic [3:0] tx_pkt_o, // packet
   input wire logic tx_done_i, // done
   input wire logic tx_ok_i, // ok
   input wire logic rx_start_i, // rx start
   input wire logic rx_word_valid_i, // word valid
   input wire logic [31:0] rx_word_i, // word
   input wire logic rx_end_i, // rx end
   input wire pbq_pkg::rx_end_t rx_end_info_i, // end info
   input wire logic rx_drop_o, // drop
   input wire pbq_pkg::mem_wr_t mem_wr_o // mem write
);
   logic [4:0] mask_q;
   logic [4:0] mask_d;
   logic [4:0] ctrl_q;
   logic [4:0] ctrl_d;
   // shadows of mask and control; hardware clearing of tx enable is not seen here
   always_comb
   begin
      mask_d = mask_q;
      ctrl_d = ctrl_q;
      if (reg_wr_i && reg_addr_i == pbq_pkg::REG_MASK) mask_d = reg_wdata_i[4:0];
      if (reg_wr_i && reg_addr_i == pbq_pkg::REG_CTRL) ctrl_d = reg_wdata_i[4:0];
   end
   always_ff @(posedge clk_i)
   begin
      mask_q <= srst_i ? 5'h00 : mask_d;
      ctrl_q <= srst_i ? 5'h04 : ctrl_d;
   end
   default clocking @(posedge clk_i); endclocking
   default disable iff (srst_i);
   rdata_source_a: assert property (reg_rdata_o != 16'h0000 |-> $past(reg_rd_i))
      else $error("read data without read");
   start_pulse_a: assert property (tx_start_o |=> !tx_start_o)
      else $error("start longer than one cycle");
   pkt_hold_a: assert property (!tx_start_o |-> $stable(tx_pkt_o))
      else $error("packet number moved");
   irq_mask_a: assert property (irq_o |-> mask_q != 5'h00)
      else $error("irq with all masked");
   start_gate_a: assert property (tx_start_o |-> $past(ctrl_q[0]) && ($past(ctrl_q[4]) || $past(tx_defer_ok_i)))
      else $error("start not permitted");
   word_write_a: assert property (rx_word_valid_i && ctrl_q[1] |=>
      (mem_wr_o.we && mem_wr_o.data == $past(rx_word_i)) || rx_drop_o) else $error("word not written");
   // the status word leaves the write port two edges after the end pulse, the count one edge later
   end_write_a: assert property (rx_end_i && ctrl_q[1] |-> ##2 mem_wr_o.we && mem_wr_o.addr[8:0] == 9'h000 &&
      mem_wr_o.data[15:0] == $past(rx_end_info_i.status, 2) ##1 mem_wr_o.we && mem_wr_o.addr[8:0] == 9'h001 &&
      mem_wr_o.data[10:0] == $past(rx_end_info_i.bytes, 3)) else $error("status words wrong");
   we_cause_a: assert property (mem_wr_o.we |-> $past(rx_word_valid_i) || $past(rx_end_i, 2) || $past(rx_end_i, 3))
      else $error("write without cause");
   cover property (tx_start_o);
   cover property (irq_o);
   cover property (mem_wr_o.we);
endmodule

// File: mac_model.sv
`timescale 1ns/10ps
// far side: answers each start with done after a programmable wait
module mac_model (
   input wire logic clk_i, // clock
   input wire logic srst_i, // reset
   input wire logic tx_start_i, // start
   input wire logic ok_i, // result wanted
   input wire logic [3:0] delay_i, // wait length
   output logic done_o, // done pulse
   output logic ok_o // result
);
   logic [3:0] cnt_q;
   // result line scrambles outside done so stale values never pass
   always_ff @(posedge clk_i)
   begin
      if (srst_i)
      begin
         cnt_q <= 4'h0;
         done_o <= 1'b0;
         ok_o <= 1'b0;
      end
      else
      begin
         done_o <= cnt_q == 4'h1;
         ok_o <= (cnt_q == 4'h1) ? ok_i : ~ok_o;
         if (tx_start_i) cnt_q <= delay_i;
         else if (cnt_q != 4'h0) cnt_q <= cnt_q - 4'h1;
      end
   end
endmodule

// File: packet_buffer_queue_manager_test.sv
`timescale 1ns/10ps
module packet_buffer_queue_manager_test;
   logic clk_i = 1'b0;
   logic srst_i = 1'b1;
   logic [3:0] reg_addr_i = 4'h0;
   logic [15:0] reg_wdata_i = 16'h0000;
   logic reg_wr_i = 1'b0;
   logic reg_rd_i = 1'b0;
   logic tx_defer_ok_i = 1'b0;
   logic rx_start_i = 1'b0;
   logic rx_word_valid_i = 1'b0;
   logic rx_end_i = 1'b0;
   logic [31:0] rx_word_i = 32'h0;
   pbq_pkg::rx_end_t rx_end_info_i = '0;
   logic [15:0] reg_rdata_o;
   logic irq_o, tx_start_o, tx_done_i, tx_ok_i, rx_drop_o;
   logic [3:0] tx_pkt_o;
   pbq_pkg::mem_wr_t mem_wr_o;
   logic mac_ok = 1'b1;
   logic [3:0] mac_dly = 4'h1;
   logic [15:0] v, pn;
   int err_count = 0;
   int total_checks = 0;
   always #5 clk_i = ~clk_i;
   packet_buffer_queue_manager dut_u (.clk_i(clk_i), .srst_i(srst_i), .reg_addr_i(reg_addr_i),
      .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
      .irq_o(irq_o), .tx_defer_ok_i(tx_defer_ok_i), .tx_start_o(tx_start_o), .tx_pkt_o(tx_pkt_o),
      .tx_done_i(tx_done_i), .tx_ok_i(tx_ok_i), .rx_start_i(rx_start_i), .rx_word_valid_i(rx_word_valid_i),
      .rx_word_i(rx_word_i), .rx_end_i(rx_end_i), .rx_end_info_i(rx_end_info_i), .rx_drop_o(rx_drop_o),
      .mem_wr_o(mem_wr_o));
   mac_model mac_u (.clk_i(clk_i), .srst_i(srst_i), .tx_start_i(tx_start_o), .ok_i(mac_ok),
      .delay_i(mac_dly), .done_o(tx_done_i), .ok_o(tx_ok_i));
   // ********************
   // bus and compare tasks
   // ********************
   task report_and_stop;
      $display("checks %0d errors %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task chk(input string name, input logic [15:0] exp, input logic [15:0] got);
      total_checks++;
      if (got !== exp)
      begin
         err_count++;
         $display("ERROR %s expected %h seen %h", name, exp, got);
      end
   endtask
   task wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk_i);
      reg_addr_i <= a;
      reg_wdata_i <= d;
      reg_wr_i <= 1'b1;
      @(posedge clk_i);
      reg_wr_i <= 1'b0;
   endtask
   // read data stand only in the cycle after the strobe
   task rd(input logic [3:0] a, input logic [15:0] m, input logic [15:0] e, input string name);
      @(posedge clk_i);
      reg_addr_i <= a;
      reg_rd_i <= 1'b1;
      @(posedge clk_i);
      reg_rd_i <= 1'b0;
      #1 v = reg_rdata_o;
      chk(name, e, v & m);
   endtask
   task wait_start;
      int i;
      i = 0;
      while (tx_start_o !== 1'b1 && i < 100)
      begin
         @(posedge clk_i);
         #1 i++;
      end
      chk("tx start", 16'h0001, {15'h0, tx_start_o});
      chk("tx packet", pn, {12'h0, tx_pkt_o});
      // a start that never came already counted as a mismatch
      if (i == 100)
         report_and_stop;
      repeat (30) @(posedge clk_i);
   endtask
   task alloc(input logic [15:0] cmd);
      wr(4'h1, cmd);
      repeat (3) @(posedge clk_i);
      rd(4'h5, 16'h0008, 16'h0008, "alloc done");
      rd(4'h3, 16'h0080, 16'h0000, "alloc result");
      pn = v & 16'h000F;
      wr(4'h5, 16'h0008);
      wr(4'h2, pn);
   endtask
   task rx_frame(input int n, input logic ok);
      @(posedge clk_i);
      rx_start_i <= 1'b1;
      @(posedge clk_i);
      rx_start_i <= 1'b0;
      for (int i = 0; i < n; i++)
      begin
         rx_word_valid_i <= 1'b1;
         rx_word_i <= 32'hA5000000 + i;
         @(posedge clk_i);
      end
      rx_word_valid_i <= 1'b0;
      rx_end_i <= 1'b1;
      rx_end_info_i <= '{status: 16'h1234, bytes: 11'h118, crc_ok: ok};
      @(posedge clk_i);
      rx_end_i <= 1'b0;
      repeat (5) @(posedge clk_i);
   endtask
   // ********************
   // main sequence
   // ********************
   initial
   begin
      repeat (20) @(posedge clk_i);
      srst_i <= 1'b0;
      rd(4'h0, 16'hFFFF, 16'h0004, "ctrl reset");
      rd(4'hF, 16'hFFFF, 16'h0000, "unmapped");
      wr(4'h6, 16'h001F);
      alloc(16'h212C);
      rd(4'h7, 16'h3F00, 16'h1E00, "pages taken");
      wr(4'h0, 16'h0005);
      wr(4'h1, 16'h4000);
      repeat (10) @(posedge clk_i);
      rd(4'h4, 16'h0080, 16'h0000, "held by deferral");
      tx_defer_ok_i <= 1'b1;
      wait_start;
      rd(4'h5, 16'h0006, 16'h0004, "drained");
      rd(4'h7, 16'h3F01, 16'h2001, "auto freed");
      wr(4'h5, 16'h001F);
      mac_ok <= 1'b0;
      mac_dly <= 4'h9;
      // packet zero is taken by the first of these allocations, so the failing packet has a nonzero number
      alloc(16'h2064);
      alloc(16'h2064);
      wr(4'h1, 16'h4000);
      wait_start;
      rd(4'h5, 16'h0006, 16'h0002, "tx fail");
      rd(4'h0, 16'h0001, 16'h0000, "tx enable off");
      rd(4'h4, 16'h000F, pn, "failed packet");
      rd(4'h7, 16'h0001, 16'h0000, "last not ok");
      // requeue in full duplex while deferral is held off
      mac_ok <= 1'b1;
      tx_defer_ok_i <= 1'b0;
      wr(4'h5, 16'h0002);
      wr(4'h2, pn);
      wr(4'h0, 16'h0015);
      wr(4'h1, 16'h4000);
      wait_start;
      rd(4'h5, 16'h0006, 16'h0004, "requeue drained");
      rx_frame(3, 1'b1);
      rd(4'h4, 16'h8000, 16'h8000, "rx while off");
      wr(4'h0, 16'h0006);
      rx_frame(70, 1'b1);
      rd(4'h4, 16'h8F00, 16'h0100, "rx queued");
      chk("irq rx", 16'h0001, {15'h0, irq_o});
      rd(4'h7, 16'h3F00, 16'h1D00, "rx pages");
      wr(4'h1, 16'h8000);
      rd(4'h4, 16'h8000, 16'h8000, "rx popped");
      rd(4'h7, 16'h3F00, 16'h1F00, "rx freed");
      wr(4'h2, 16'h0000);
      wr(4'h1, 16'h6000);
      rd(4'h7, 16'h3F00, 16'h2000, "released");
      wr(4'h0, 16'h000E);
      rx_frame(2, 1'b0);
      rd(4'h5, 16'h0011, 16'h0011, "bad frame flag");
      rd(4'h4, 16'h8000, 16'h8000, "bad not queued");
      // mask off while the flag still stands, so the gating itself is seen
      wr(4'h6, 16'h0000);
      #1 chk("irq masked", 16'h0000, {15'h0, irq_o});
      wr(4'h5, 16'h0010);
      wr(4'h0, 16'h0006);
      rx_frame(2, 1'b0);
      rd(4'h5, 16'h0010, 16'h0000, "bad frame quiet");
      report_and_stop;
   end
   initial
   begin
      repeat (20000) @(posedge clk_i);
      err_count++;
      $display("ERROR watchdog expected finish seen timeout");
      report_and_stop;
   end
endmodule
bind packet_buffer_queue_manager pbq_checker chk_u (.clk_i(clk_i), .srst_i(srst_i), .reg_addr_i(reg_addr_i),
   .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
   .irq_o(irq_o), .tx_defer_ok_i(tx_defer_ok_i), .tx_start_o(tx_start_o), .tx_pkt_o(tx_pkt_o),
   .tx_done_i(tx_done_i), .tx_ok_i(tx_ok_i), .rx_start_i(rx_start_i), .rx_word_valid_i(rx_word_valid_i),
   .rx_word_i(rx_word_i), .rx_end_i(rx_end_i), .rx_end_info_i(rx_end_info_i), .rx_drop_o(rx_drop_o),
   .mem_wr_o(mem_wr_o));
